/* rtl/bsq_sequencer.sv */
// Burner flame-safeguard sequencer top level
module bsq_sequencer #(
    parameter int TICK_CYCLES = bsq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Configuration
    input wire bsq_pkg::bsq_cfg_t cfg,
    // Line and control inputs
    input wire logic line_ok,
    input wire logic call_for_heat,
    input wire logic limits_ok,
    input wire logic airflow_interlock_input,
    input wire logic flame_detected,
    input wire logic run_test_switch,
    input wire logic lockout_reset,
    // Output terminal feedback
    input wire bsq_pkg::bsq_sense_t sense,
    // Actuator drives
    output bsq_pkg::bsq_drive_t drive_q,
    // Status
    output bsq_pkg::bsq_state_t state_q,
    output logic hold_active_q,
    output logic lockout_q,
    output logic [7:0] fault_code_q
);

    // ------------------------------------------------------------
    // Millisecond timebase
    // ------------------------------------------------------------
    logic [31:0] pre_q;
    logic tick_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else if (pre_q == 32'(TICK_CYCLES - 1)) begin
            pre_q <= '0;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Derived settings
    // ------------------------------------------------------------
    logic [bsq_pkg::TW-1:0] purge_len;
    logic [bsq_pkg::TW-1:0] air_len;
    logic [bsq_pkg::TW-1:0] trial_len;
    logic [bsq_pkg::TW-1:0] halt_len;
    logic [bsq_pkg::TW-1:0] flame_failure_response_time_len;
    logic long_trial;
    logic test_ok;
    logic circuits_ok;
    logic any_sensed;

    always_comb begin
        if (cfg.purge_ms < bsq_pkg::T_PURGE_MIN_MS) begin
            purge_len = bsq_pkg::T_PURGE_MIN_MS;
        end else if (cfg.purge_ms > bsq_pkg::T_PURGE_MAX_MS) begin
            purge_len = bsq_pkg::T_PURGE_MAX_MS;
        end else begin
            purge_len = cfg.purge_ms;
        end
        air_len = (purge_len < bsq_pkg::T_AIRFLOW_MS) ? purge_len :
            bsq_pkg::T_AIRFLOW_MS;
        long_trial = cfg.fixed_trial | cfg.pilot_trial_time_jumper;
        trial_len = long_trial ? bsq_pkg::T_PILOT_TRIAL_PERIOD_LONG_MS :
            bsq_pkg::T_PILOT_TRIAL_PERIOD_SHORT_MS;
        halt_len = long_trial ? bsq_pkg::T_HALT_LONG_MS :
            bsq_pkg::T_HALT_SHORT_MS;
        flame_failure_response_time_len = cfg.flame_failure_response_time_long ? bsq_pkg::T_FLAME_FAILURE_RESPONSE_TIME_LONG_MS :
            bsq_pkg::T_FLAME_FAILURE_RESPONSE_TIME_SHORT_MS;
        // With interrupted pilot, main terminal live during the trial means it is strapped over
        test_ok = run_test_switch & ~(cfg.interrupted_pilot & sense.main);
        any_sensed = sense.ignition | sense.pilot | sense.main |
            sense.delayed_main;
        circuits_ok = limits_ok & ~any_sensed;
    end

    // ------------------------------------------------------------
    // Jumper watch and operating hours
    // ------------------------------------------------------------
    logic jcap_valid_q;
    logic [2:0] jcap_q;
    logic [bsq_pkg::TW-1:0] ms_q;
    logic [bsq_pkg::TW-1:0] secs_q;
    logic fault110_q;
    logic [2:0] jnow;

    assign jnow = {cfg.pilot_trial_time_jumper,
        cfg.flame_failure_action_jumper,
        cfg.airflow_failure_action_jumper};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            jcap_valid_q <= 1'b0;
            jcap_q <= '0;
        end else if (!jcap_valid_q) begin
            jcap_valid_q <= 1'b1;
            jcap_q <= jnow;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ms_q <= '0;
            secs_q <= '0;
        end else if (tick_q && secs_q < bsq_pkg::T_JUMPER_LOCK_S) begin
            if (ms_q == bsq_pkg::MS_PER_S - 21'h00_0001) begin
                ms_q <= '0;
                secs_q <= secs_q + 21'h00_0001;
            end else begin
                ms_q <= ms_q + 21'h00_0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fault110_q <= 1'b0;
        end else if (jcap_valid_q && jnow != jcap_q &&
                secs_q >= bsq_pkg::T_JUMPER_LOCK_S) begin
            fault110_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sequence state machine
    // ------------------------------------------------------------
    logic [bsq_pkg::TW-1:0] tmr_q;
    logic [bsq_pkg::TW-1:0] aux_q;
    logic proven_q;
    logic aired_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= bsq_pkg::ST_INIT;
            tmr_q <= '0;
            aux_q <= '0;
            proven_q <= 1'b0;
            aired_q <= 1'b0;
        end else if (fault110_q && state_q != bsq_pkg::ST_LOCKOUT) begin
            state_q <= bsq_pkg::ST_LOCKOUT;
            tmr_q <= '0;
        end else if (!line_ok && state_q != bsq_pkg::ST_LOCKOUT &&
                state_q != bsq_pkg::ST_HOLD) begin
            state_q <= bsq_pkg::ST_HOLD;
            tmr_q <= '0;
            aux_q <= '0;
        end else if (tick_q) begin
            case (state_q)
                bsq_pkg::ST_INIT: begin
                    tmr_q <= tmr_q + 21'h00_0001;
                    if (tmr_q >= bsq_pkg::T_INIT_MS) begin
                        state_q <= bsq_pkg::ST_STANDBY;
                        tmr_q <= '0;
                        aux_q <= '0;
                    end
                end
                bsq_pkg::ST_HOLD: begin
                    tmr_q <= tmr_q + 21'h00_0001;
                    aux_q <= line_ok ? aux_q + 21'h00_0001 : '0;
                    if (tmr_q >= bsq_pkg::T_HOLD_MAX_MS) begin
                        state_q <= bsq_pkg::ST_LOCKOUT;
                        tmr_q <= '0;
                    end else if (line_ok &&
                            tmr_q >= bsq_pkg::T_HOLD_MIN_MS) begin
                        state_q <= bsq_pkg::ST_INIT;
                        tmr_q <= '0;
                    end
                end
                bsq_pkg::ST_STANDBY: begin
                    aux_q <= flame_detected ? aux_q + 21'h00_0001 : '0;
                    if (any_sensed ||
                            aux_q >= bsq_pkg::T_STBY_FLAME_MS) begin
                        state_q <= bsq_pkg::ST_LOCKOUT;
                    end else if (call_for_heat && circuits_ok &&
                            !flame_detected) begin
                        state_q <= bsq_pkg::ST_PREPURGE;
                        tmr_q <= '0;
                        aux_q <= '0;
                        aired_q <= 1'b0;
                    end
                end
                bsq_pkg::ST_PREPURGE: begin
                    if (!run_test_switch) begin
                        tmr_q <= tmr_q + 21'h00_0001;
                    end
                    aux_q <= aux_q + 21'h00_0001;
                    if (airflow_interlock_input) begin
                        aired_q <= 1'b1;
                    end
                    if (!call_for_heat) begin
                        state_q <= bsq_pkg::ST_STANDBY;
                        aux_q <= '0;
                    end else if (flame_detected || sense.main ||
                            sense.ignition || sense.delayed_main) begin
                        state_q <= bsq_pkg::ST_LOCKOUT;
                    end else if ((aired_q && !airflow_interlock_input) ||
                            (!airflow_interlock_input &&
                            aux_q >= air_len)) begin
                        if (!cfg.airflow_failure_action_jumper) begin
                            state_q <= bsq_pkg::ST_LOCKOUT;
                        end else begin
                            tmr_q <= '0;
                            aux_q <= '0;
                            aired_q <= 1'b0;
                        end
                    end else if (tmr_q >= purge_len) begin
                        state_q <= bsq_pkg::ST_PILOT;
                        tmr_q <= '0;
                        aux_q <= '0;
                        proven_q <= 1'b0;
                    end
                end
                bsq_pkg::ST_PILOT: begin
                    if (!(test_ok && tmr_q < halt_len)) begin
                        tmr_q <= tmr_q + 21'h00_0001;
                    end
                    aux_q <= (test_ok && !flame_detected) ?
                        aux_q + 21'h00_0001 : '0;
                    if (flame_detected && tmr_q >= bsq_pkg::T_FIXED_IGN_MS) begin
                        proven_q <= 1'b1;
                    end else if (flame_detected && !cfg.fixed_trial) begin
                        proven_q <= 1'b1;
                    end
                    if (aux_q >= bsq_pkg::T_TEST_FLAMEOUT_MS ||
                            !airflow_interlock_input && 
                            !cfg.airflow_failure_action_jumper) begin
                        state_q <= bsq_pkg::ST_LOCKOUT;
                    end else if (tmr_q >= trial_len) begin
                        tmr_q <= '0;
                        aux_q <= '0;
                        if (!flame_detected) begin
                            state_q <= bsq_pkg::ST_LOCKOUT;
                        end else if (cfg.interrupted_pilot) begin
                            state_q <= bsq_pkg::ST_MAIN;
                        end else begin
                            state_q <= bsq_pkg::ST_RUN;
                        end
                    end
                end
                bsq_pkg::ST_MAIN, bsq_pkg::ST_RUN: begin
                    tmr_q <= tmr_q + 21'h00_0001;
                    aux_q <= flame_detected ? '0 : aux_q + 21'h00_0001;
                    if (aux_q >= flame_failure_response_time_len) begin
                        tmr_q <= '0;
                        aux_q <= '0;
                        aired_q <= 1'b0;
                        state_q <= cfg.flame_failure_action_jumper ?
                            bsq_pkg::ST_PREPURGE : bsq_pkg::ST_LOCKOUT;
                    end else if (!call_for_heat) begin
                        tmr_q <= '0;
                        aux_q <= '0;
                        state_q <= cfg.post_purge ? bsq_pkg::ST_POST :
                            bsq_pkg::ST_STANDBY;
                    end else if (state_q == bsq_pkg::ST_MAIN &&
                            tmr_q >= bsq_pkg::T_MAIN_TRIAL_PERIOD_MS) begin
                        state_q <= bsq_pkg::ST_RUN;
                        tmr_q <= '0;
                    end
                end
                bsq_pkg::ST_POST: begin
                    tmr_q <= tmr_q + 21'h00_0001;
                    if (tmr_q >= bsq_pkg::T_POST_MS) begin
                        state_q <= bsq_pkg::ST_STANDBY;
                        tmr_q <= '0;
                        aux_q <= '0;
                    end
                end
                bsq_pkg::ST_LOCKOUT: begin
                    if (lockout_reset && !fault110_q) begin
                        state_q <= bsq_pkg::ST_INIT;
                        tmr_q <= '0;
                        aux_q <= '0;
                    end
                end
                default: begin
                    state_q <= bsq_pkg::ST_LOCKOUT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output drives
    // ------------------------------------------------------------
    bsq_pkg::bsq_drive_t drive_d;
    logic ign_pilot;

    always_comb begin
        drive_d = '0;
        if (cfg.fixed_trial && tmr_q < bsq_pkg::T_FIXED_IGN_MS) begin
            ign_pilot = ~flame_detected;
        end else begin
            ign_pilot = ~proven_q;
        end
        case (state_q)
            bsq_pkg::ST_PREPURGE: begin
                drive_d.blower = 1'b1;
            end
            bsq_pkg::ST_PILOT: begin
                drive_d.blower = 1'b1;
                drive_d.pilot = 1'b1;
                drive_d.ignition = ign_pilot;
            end
            bsq_pkg::ST_MAIN: begin
                drive_d.blower = 1'b1;
                drive_d.pilot = 1'b1;
                drive_d.main = 1'b1;
            end
            bsq_pkg::ST_RUN: begin
                drive_d.blower = 1'b1;
                drive_d.main = 1'b1;
                drive_d.pilot = ~cfg.interrupted_pilot;
                drive_d.delayed_main = cfg.interrupted_pilot;
            end
            bsq_pkg::ST_POST: begin
                drive_d.blower = 1'b1;
            end
            default: begin
                drive_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            drive_q <= '0;
            hold_active_q <= 1'b0;
            lockout_q <= 1'b0;
            fault_code_q <= bsq_pkg::FAULT_NONE;
        end else begin
            drive_q <= drive_d;
            hold_active_q <= (state_q == bsq_pkg::ST_HOLD);
            lockout_q <= (state_q == bsq_pkg::ST_LOCKOUT);
            fault_code_q <= fault110_q ? bsq_pkg::FAULT_JUMPER :
                bsq_pkg::FAULT_NONE;
        end
    end

endmodule : bsq_sequencer

/* rtl/bsq_pkg.sv */
// Constants, types and timing for the burner flame-safeguard sequencer
package bsq_pkg;

    // ------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TW = 21;

    // ------------------------------------------------------------
    // Times in milliseconds; jumper lock time in seconds
    // ------------------------------------------------------------
    localparam logic [TW-1:0] T_INIT_MS = 21'h00_2710;
    localparam logic [TW-1:0] T_HOLD_MIN_MS = 21'h00_1388;
    localparam logic [TW-1:0] T_HOLD_MAX_MS = 21'h03_A980;
    localparam logic [TW-1:0] T_AIRFLOW_MS = 21'h00_2710;
    localparam logic [TW-1:0] T_PURGE_MIN_MS = 21'h00_07D0;
    localparam logic [TW-1:0] T_PURGE_MAX_MS = 21'h1B_7740;
    localparam logic [TW-1:0] T_PILOT_TRIAL_PERIOD_LONG_MS = 21'h00_2710;
    localparam logic [TW-1:0] T_PILOT_TRIAL_PERIOD_SHORT_MS = 21'h00_0FA0;
    localparam logic [TW-1:0] T_FIXED_IGN_MS = 21'h00_1F40;
    localparam logic [TW-1:0] T_HALT_LONG_MS = 21'h00_1F40;
    localparam logic [TW-1:0] T_HALT_SHORT_MS = 21'h00_0BB8;
    localparam logic [TW-1:0] T_TEST_FLAMEOUT_MS = 21'h00_3A98;
    localparam logic [TW-1:0] T_FLAME_FAILURE_RESPONSE_TIME_SHORT_MS = 21'h00_0320;
    localparam logic [TW-1:0] T_FLAME_FAILURE_RESPONSE_TIME_LONG_MS = 21'h00_0BB8;
    localparam logic [TW-1:0] T_MAIN_TRIAL_PERIOD_MS = 21'h00_2710;
    localparam logic [TW-1:0] T_POST_MS = 21'h00_3A98;
    localparam logic [TW-1:0] T_STBY_FLAME_MS = 21'h00_7530;
    localparam logic [TW-1:0] MS_PER_S = 21'h00_03E8;
    localparam logic [TW-1:0] T_JUMPER_LOCK_S = 21'h0A_FC80;

    // ------------------------------------------------------------
    // Fault codes
    // ------------------------------------------------------------
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [7:0] FAULT_JUMPER = 8'h6E;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_INIT = 4'h0,
        ST_HOLD = 4'h1,
        ST_STANDBY = 4'h2,
        ST_PREPURGE = 4'h3,
        ST_PILOT = 4'h4,
        ST_MAIN = 4'h5,
        ST_RUN = 4'h6,
        ST_POST = 4'h7,
        ST_LOCKOUT = 4'h8
    } bsq_state_t;

    typedef struct packed {
        logic pilot_trial_time_jumper;
        logic flame_failure_action_jumper;
        logic airflow_failure_action_jumper;
        logic interrupted_pilot;
        logic post_purge;
        logic fixed_trial;
        logic flame_failure_response_time_long;
        logic [TW-1:0] purge_ms;
    } bsq_cfg_t;

    typedef struct packed {
        logic ignition;
        logic pilot;
        logic main;
        logic delayed_main;
    } bsq_sense_t;

    typedef struct packed {
        logic blower;
        logic ignition;
        logic pilot;
        logic main;
        logic delayed_main;
    } bsq_drive_t;

endpackage : bsq_pkg

/* verification/bsq_checker.sv */
// Assertion checker for the burner flame-safeguard sequencer
module bsq_checker #(
    parameter int TICK_CYCLES = bsq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Line and control inputs
    input wire logic line_ok,
    input wire logic call_for_heat,
    input wire logic limits_ok,
    input wire logic airflow_interlock_input,
    input wire logic flame_detected,
    // Outputs
    input wire bsq_pkg::bsq_drive_t drive_q,
    input wire bsq_pkg::bsq_state_t state_q,
    input wire logic lockout_q
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT_MIN = int'(bsq_pkg::T_INIT_MS) * TICK_CYCLES;
    localparam int HOLD_MIN = int'(bsq_pkg::T_HOLD_MIN_MS) * TICK_CYCLES;
    bsq_pkg::bsq_state_t prev_q;
    int run_q;

    // ------------------------------------------------------------
    // Cycles spent in the present state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_q <= bsq_pkg::ST_INIT;
            run_q <= 0;
        end else begin
            prev_q <= state_q;
            run_q <= (state_q != prev_q) ? 1 : run_q + 1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_init_len;
        state_q == bsq_pkg::ST_INIT |=>
            state_q != bsq_pkg::ST_STANDBY || run_q >= INIT_MIN;
    endproperty
    a_init_len: assert property (p_init_len) else $error("short init");
    property p_hold_min;
        state_q == bsq_pkg::ST_HOLD |=>
            state_q != bsq_pkg::ST_INIT || run_q >= HOLD_MIN;
    endproperty
    a_hold_min: assert property (p_hold_min) else $error("short hold");
    property p_line_drop;
        !line_ok && state_q != bsq_pkg::ST_LOCKOUT |=>
            state_q == bsq_pkg::ST_HOLD;
    endproperty
    a_line_drop: assert property (p_line_drop) else $error("no hold");
    property p_init_dark;
        state_q == bsq_pkg::ST_INIT |=> !drive_q.blower;
    endproperty
    a_init_dark: assert property (p_init_dark) else $error("fan in init");
    property p_stby_gate;
        state_q == bsq_pkg::ST_STANDBY && !(call_for_heat && limits_ok) |=>
            state_q != bsq_pkg::ST_PREPURGE;
    endproperty
    a_stby_gate: assert property (p_stby_gate) else $error("bad start");
    property p_purge_fan;
        state_q == bsq_pkg::ST_PREPURGE |=> drive_q.blower;
    endproperty
    a_purge_fan: assert property (p_purge_fan) else $error("fan off");
    property p_trial_on;
        state_q == bsq_pkg::ST_PILOT && prev_q != bsq_pkg::ST_PILOT |=>
            drive_q.pilot && drive_q.ignition;
    endproperty
    a_trial_on: assert property (p_trial_on) else $error("trial off");
    property p_run_stay;
        state_q == bsq_pkg::ST_RUN && call_for_heat && line_ok &&
            flame_detected && airflow_interlock_input |=>
            state_q == bsq_pkg::ST_RUN;
    endproperty
    a_run_stay: assert property (p_run_stay) else $error("left run");
    property p_post;
        state_q == bsq_pkg::ST_POST |=> drive_q == 5'h10;
    endproperty
    a_post: assert property (p_post) else $error("post drives");
    property p_lock_dark;
        state_q == bsq_pkg::ST_LOCKOUT |=> drive_q == 5'h00 && lockout_q;
    endproperty
    a_lock_dark: assert property (p_lock_dark) else $error("lock drives");
endmodule : bsq_checker

bind bsq_sequencer bsq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_bsq_checker (
    .clk(clk), .rstn(rstn), .line_ok(line_ok),
    .call_for_heat(call_for_heat), .limits_ok(limits_ok),
    .airflow_interlock_input(airflow_interlock_input),
    .flame_detected(flame_detected), .drive_q(drive_q),
    .state_q(state_q), .lockout_q(lockout_q)
);

/* verification/bsq_burner_model.sv */
// Far-side model: flame amplifier, airflow switch, terminal feedback
module bsq_burner_model (
    // Clock and scenario control
    input wire logic clk,
    input wire logic fuel_ok,
    // Sequencer drives
    input wire bsq_pkg::bsq_drive_t drive,
    // Responses
    output logic flame_detected,
    output logic airflow_interlock_input,
    output bsq_pkg::bsq_sense_t sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lit_q = 3'h0;
    logic [1:0] air_q = 2'h0;

    // Terminals show what is driven
    assign sense = {drive.ignition, drive.pilot, drive.main, drive.delayed_main};
    // Flame lights a few cycles after the igniter, then holds on fuel
    always @(posedge clk) begin
        if (!fuel_ok || !(drive.pilot || drive.main)) begin
            lit_q <= 3'h0;
        end else if (lit_q != 3'h7 && (drive.ignition || lit_q != 3'h0)) begin
            lit_q <= lit_q + 3'h1;
        end
    end
    assign flame_detected = lit_q >= 3'h3;
    // Airflow switch closes a few cycles after the blower starts
    always @(posedge clk) begin
        if (!drive.blower) begin
            air_q <= 2'h0;
        end else if (air_q != 2'h3) begin
            air_q <= air_q + 2'h1;
        end
    end
    assign airflow_interlock_input = air_q == 2'h3;
endmodule : bsq_burner_model

/* verification/tb.sv */
// Self-checking bench for the burner flame-safeguard sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 1;
    localparam int MAX_CYC = 90000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic line_ok, call_for_heat, limits_ok, run_test_switch, lockout_reset;
    logic fuel_ok, flame, airflow, hold_q, lock_q;
    logic [7:0] fault_q;
    logic [31:0] seed = 32'h4457_102e;
    bsq_pkg::bsq_cfg_t cfg;
    bsq_pkg::bsq_sense_t sense;
    bsq_pkg::bsq_drive_t drive_q;
    bsq_pkg::bsq_state_t state_q;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int t0 = 0;
    int dt = 0;

    always #2.5 clk = ~clk;

    bsq_sequencer #(.TICK_CYCLES(TC)) u_bsq_sequencer (
        .clk(clk), .rstn(rstn), .cfg(cfg), .line_ok(line_ok),
        .call_for_heat(call_for_heat), .limits_ok(limits_ok),
        .airflow_interlock_input(airflow), .flame_detected(flame),
        .run_test_switch(run_test_switch), .lockout_reset(lockout_reset),
        .sense(sense), .drive_q(drive_q), .state_q(state_q),
        .hold_active_q(hold_q), .lockout_q(lock_q), .fault_code_q(fault_q)
    );
    bsq_burner_model u_bsq_burner_model (
        .clk(clk), .fuel_ok(fuel_ok), .drive(drive_q),
        .flame_detected(flame), .airflow_interlock_input(airflow),
        .sense(sense)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic in_span(input int n, input logic [20:0] ms);
        return n >= int'(ms) * TC && n <= (int'(ms) + 1) * TC + 2;
    endfunction : in_span
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask : check
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic wait_state(input bsq_pkg::bsq_state_t s, input int lim);
        int n;
        n = 0;
        while (state_q !== s && n < lim) begin
            step();
            n++;
        end
        check(state_q === s, "state not reached");
        dt = cyc - t0;
        t0 = cyc;
    endtask : wait_state
    task automatic reset_dut();
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        t0 = cyc;
    endtask : reset_dut
    task automatic burn(input logic [20:0] pms, input logic lit);
        fuel_ok = lit;
        call_for_heat = 1'b1;
        limits_ok = 1'b0;
        repeat (20) step();
        check(state_q === bsq_pkg::ST_STANDBY, "start without limits");
        limits_ok = 1'b1;
        wait_state(bsq_pkg::ST_PREPURGE, 4);
        step();
        check(drive_q.blower === 1'b1, "blower off");
        if (!lit) begin
            run_test_switch = 1'b1;
            repeat (500) step();
            run_test_switch = 1'b0;
            t0 = t0 + 500;
        end
        wait_state(bsq_pkg::ST_PILOT, 40000);
        check(in_span(dt + 1, pms), "purge length");
        step();
        check(drive_q.pilot === 1'b1 && drive_q.ignition === 1'b1, "trial");
        if (!lit) begin
            wait_state(bsq_pkg::ST_LOCKOUT, 9000);
            step();
            check(drive_q === 5'h00 && lock_q === 1'b1, "lockout drives");
        end else begin
            repeat (8) step();
            check(flame === 1'b1 && drive_q.ignition === 1'b0, "igniter on");
            wait_state(bsq_pkg::ST_MAIN, 9000);
            step();
            check(drive_q === 5'h16, "main trial drives");
            wait_state(bsq_pkg::ST_RUN, 11000);
            check(in_span(dt + 1, bsq_pkg::T_MAIN_TRIAL_PERIOD_MS), "main trial");
            step();
            check(drive_q === 5'h13, "run drives");
            repeat (200) step();
            check(state_q === bsq_pkg::ST_RUN, "left run");
            call_for_heat = 1'b0;
            wait_state(bsq_pkg::ST_POST, 3);
            step();
            check(drive_q === 5'h10, "post drives");
            wait_state(bsq_pkg::ST_STANDBY, 40000);
        end
    endtask : burn

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC) begin
            n_errors++;
            $display("wrong value at %0t ns: run too long", $time);
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        line_ok = 1'b1;
        call_for_heat = 1'b0;
        limits_ok = 1'b1;
        run_test_switch = 1'b0;
        lockout_reset = 1'b0;
        fuel_ok = 1'b1;
        seed = lfsr(seed);
        cfg = {6'h1E, seed[9], 21'h00_07D0 + 21'(seed[8:0])};
        reset_dut();
        check(state_q === bsq_pkg::ST_INIT && fault_q === 8'h00, "reset");
        wait_state(bsq_pkg::ST_STANDBY, 40000);
        $display("test initiate finished");
        line_ok = 1'b0;
        wait_state(bsq_pkg::ST_HOLD, 3);
        repeat (1000) step();
        line_ok = 1'b1;
        check(hold_q === 1'b1, "hold flag");
        wait_state(bsq_pkg::ST_INIT, 40000);
        wait_state(bsq_pkg::ST_STANDBY, 40000);
        $display("test line hold finished");
        burn(cfg.purge_ms, 1'b1);
        $display("test normal cycle finished");
        cfg.purge_ms = 21'h00_0005;
        reset_dut();
        wait_state(bsq_pkg::ST_STANDBY, 40000);
        burn(bsq_pkg::T_PURGE_MIN_MS, 1'b0);
        repeat (100) step();
        check(state_q === bsq_pkg::ST_LOCKOUT, "left lockout");
        lockout_reset = 1'b1;
        wait_state(bsq_pkg::ST_INIT, 3);
        lockout_reset = 1'b0;
        $display("test pilot failure finished");
        complete_run();
    end
endmodule : tb
